// >>> design/xadl_pkg.sv
// Overview of operation
// - Word 00 0000 0110 0fff copies the accumulator into the port direction register picked by fff, 5 to 7 only, with no flag change.
// - Port direction registers also stay readable and writable as ordinary data-memory locations.
// - Word 11 1010 kkkk kkkk XORs the accumulator with the literal in the low byte.
// - The literal XOR writes the accumulator and changes only the zero flag.
// - Word 00 0110 dfff ffff XORs the accumulator with the file register at the 7-bit address, changing only zero.
// - With the destination bit at 0 the file XOR result goes to the accumulator and the file stays unchanged.
// - With the destination bit at 1 the file XOR result goes to the file register and the accumulator stays unchanged.
package xadl_pkg;
    localparam int DATA_W = 8;
    localparam int INSN_W = 14;
    localparam int ADDR_W = 7;
    localparam logic [INSN_W-1:0] LPD_MASK = 14'h3FF8;
    localparam logic [INSN_W-1:0] LPD_CODE = 14'h0060;
    localparam logic [INSN_W-1:0] XLA_MASK = 14'h3F00;
    localparam logic [INSN_W-1:0] XLA_CODE = 14'h3A00;
    localparam logic [INSN_W-1:0] XAF_MASK = 14'h3F00;
    localparam logic [INSN_W-1:0] XAF_CODE = 14'h0600;
    localparam int DEST_BIT = 7;
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;
    localparam logic [2:0] DIR_SEL_MAX = 3'h7;
    // Data-memory addresses at which the three direction registers are mapped.
    localparam logic [ADDR_W-1:0] DIR_ADDR_5 = 7'h05;
    localparam logic [ADDR_W-1:0] DIR_ADDR_6 = 7'h06;
    localparam logic [ADDR_W-1:0] DIR_ADDR_7 = 7'h07;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;
    localparam logic ZERO_RST = 1'b0;
    typedef enum logic [1:0] {XADL_NONE, XADL_LPD, XADL_XLA, XADL_XAF} xadl_op_e;
endpackage

// >>> design/xadl_core.sv
`timescale 1ns/1ps
module xadl_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic insn_valid,
    input wire logic [xadl_pkg::INSN_W-1:0] insn,
    input wire logic [xadl_pkg::DATA_W-1:0] file_rdata,
    input wire logic mem_we,
    input wire logic [xadl_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [xadl_pkg::DATA_W-1:0] mem_wdata,
    output logic [xadl_pkg::ADDR_W-1:0] file_addr,
    output logic file_we,
    output logic [xadl_pkg::DATA_W-1:0] file_wdata,
    output logic [xadl_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic [xadl_pkg::DATA_W-1:0] dir5,
    output logic [xadl_pkg::DATA_W-1:0] dir6,
    output logic [xadl_pkg::DATA_W-1:0] dir7,
    output logic dir_rd_hit,
    output logic [xadl_pkg::DATA_W-1:0] dir_rdata,
    output logic done
);
    import xadl_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic zero;
        logic [DATA_W-1:0] dir5;
        logic [DATA_W-1:0] dir6;
        logic [DATA_W-1:0] dir7;
        logic [ADDR_W-1:0] faddr;
        logic fwe;
        logic [DATA_W-1:0] fwdata;
        logic rd_hit;
        logic [DATA_W-1:0] rdata;
        logic done;
    } xadl_state_s;

    xadl_state_s st;
    xadl_state_s next_st;
    xadl_op_e op;
    logic [DATA_W-1:0] xres;
    logic [2:0] sel;

    function automatic xadl_op_e decode(input logic [INSN_W-1:0] w);
        if ((w & LPD_MASK) == LPD_CODE) begin
            return XADL_LPD;
        end else if ((w & XLA_MASK) == XLA_CODE) begin
            return XADL_XLA;
        end else if ((w & XAF_MASK) == XAF_CODE) begin
            return XADL_XAF;
        end
        return XADL_NONE;
    endfunction

    always_comb begin
        op = insn_valid ? decode(insn) : XADL_NONE;
        sel = insn[2:0];
        xres = acc;
        next_st = st;
        next_st.fwe = 1'b0;
        next_st.done = 1'b0;
        next_st.faddr = insn[ADDR_W-1:0];
        next_st.fwdata = acc ^ file_rdata;
        next_st.rd_hit = (mem_addr == DIR_ADDR_5) || (mem_addr == DIR_ADDR_6) || (mem_addr == DIR_ADDR_7);
        case (mem_addr)
            DIR_ADDR_5: next_st.rdata = st.dir5;
            DIR_ADDR_6: next_st.rdata = st.dir6;
            DIR_ADDR_7: next_st.rdata = st.dir7;
            default: next_st.rdata = 8'h00;
        endcase
        // Direct writes are applied first so that a same-cycle direction load wins.
        if (mem_we) begin
            case (mem_addr)
                DIR_ADDR_5: next_st.dir5 = mem_wdata;
                DIR_ADDR_6: next_st.dir6 = mem_wdata;
                DIR_ADDR_7: next_st.dir7 = mem_wdata;
                default: ;
            endcase
        end
        case (op)
            XADL_LPD: begin
                next_st.done = 1'b1;
                case (sel)
                    3'h5: next_st.dir5 = st.acc;
                    3'h6: next_st.dir6 = st.acc;
                    3'h7: next_st.dir7 = st.acc;
                    default: ;
                endcase
            end
            XADL_XLA: begin
                xres = st.acc ^ insn[DATA_W-1:0];
                next_st.acc = xres;
                next_st.zero = (xres == 8'h00);
                next_st.done = 1'b1;
            end
            XADL_XAF: begin
                xres = st.acc ^ file_rdata;
                next_st.zero = (xres == 8'h00);
                next_st.done = 1'b1;
                if (insn[DEST_BIT]) begin
                    next_st.fwe = 1'b1;
                end else begin
                    next_st.acc = xres;
                end
            end
            default: ;
        endcase
        // Reset overrides any instruction or direct write of the same cycle.
        if (srst) begin
            next_st = '0;
            next_st.acc = ACC_RST;
            next_st.zero = ZERO_RST;
            next_st.dir5 = DIR_RST;
            next_st.dir6 = DIR_RST;
            next_st.dir7 = DIR_RST;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign acc = st.acc;
    assign zero_flag = st.zero;
    assign dir5 = st.dir5;
    assign dir6 = st.dir6;
    assign dir7 = st.dir7;
    assign file_addr = st.faddr;
    assign file_we = st.fwe;
    assign file_wdata = st.fwdata;
    assign dir_rd_hit = st.rd_hit;
    assign dir_rdata = st.rdata;
    assign done = st.done;

    sequence s_lit_issue;
        insn_valid && ((insn & XLA_MASK) == XLA_CODE);
    endsequence

    sequence s_file_issue(logic d);
        insn_valid && ((insn & XAF_MASK) == XAF_CODE) && (insn[DEST_BIT] == d) && !mem_we;
    endsequence

    a_dir_load_acc: assert property (@(posedge clk) disable iff (srst)
        insn_valid && ((insn & LPD_MASK) == LPD_CODE) && insn[2:0] == 3'h6 && !mem_we
        |=> dir6 == $past(acc) && $stable(zero_flag) && $stable(acc))
        else $error("direction load did not copy accumulator");
    a_dir_write_direct: assert property (@(posedge clk) disable iff (srst)
        mem_we && mem_addr == DIR_ADDR_5 && !(insn_valid && (insn & LPD_MASK) == LPD_CODE)
        |=> dir5 == $past(mem_wdata))
        else $error("direct write to direction register lost");
    a_dir_read_direct: assert property (@(posedge clk) disable iff (srst)
        mem_addr == DIR_ADDR_7 && !mem_we |=> dir_rd_hit && dir_rdata == $past(dir7))
        else $error("direction register read wrong");
    a_lit_xor_acc: assert property (@(posedge clk) disable iff (srst)
        s_lit_issue |=> acc == ($past(acc) ^ $past(insn[7:0])))
        else $error("literal XOR result wrong");
    a_lit_xor_zero: assert property (@(posedge clk) disable iff (srst)
        s_lit_issue |=> zero_flag == (acc == 8'h00) && done)
        else $error("literal XOR zero flag wrong");
    a_file_xor_acc: assert property (@(posedge clk) disable iff (srst)
        s_file_issue(1'b0) |=> acc == ($past(acc) ^ $past(file_rdata)) && !file_we)
        else $error("file XOR to accumulator wrong");
    a_file_xor_file: assert property (@(posedge clk) disable iff (srst)
        s_file_issue(1'b1) |=> file_we && file_wdata == ($past(acc) ^ $past(file_rdata)) && $stable(acc)
        && file_addr == $past(insn[6:0]))
        else $error("file XOR write back wrong");
    a_file_xor_zero: assert property (@(posedge clk) disable iff (srst)
        s_file_issue(1'b1) |=> zero_flag == (file_wdata == 8'h00))
        else $error("file XOR zero flag wrong");
    a_one_cycle_done: assert property (@(posedge clk) disable iff (srst)
        insn_valid && decode(insn) != XADL_NONE |=> done ##1 (done == $past(insn_valid && decode(insn) != XADL_NONE)))
        else $error("instruction not done in one cycle");

    // Direction loads to the other selections, refused selections and the write priority.
    sequence s_dir_issue(logic [2:0] f);
        insn_valid && ((insn & LPD_MASK) == LPD_CODE) && (insn[2:0] == f) && !mem_we;
    endsequence

    a_dir_load_five: assert property (@(posedge clk) disable iff (srst)
        s_dir_issue(3'h5) |=> dir5 == $past(acc) && $stable(zero_flag) && $stable(acc) && !file_we)
        else $error("direction load to five did not copy accumulator");

    a_dir_load_seven: assert property (@(posedge clk) disable iff (srst)
        s_dir_issue(3'h7) |=> dir7 == $past(acc) && $stable(zero_flag) && $stable(acc) && !file_we)
        else $error("direction load to seven did not copy accumulator");

    a_dir_refused_sel: assert property (@(posedge clk) disable iff (srst)
        insn_valid && ((insn & LPD_MASK) == LPD_CODE) && insn[2:0] < DIR_SEL_MIN && !mem_we
        |=> $stable(dir5) && $stable(dir6) && $stable(dir7) && $stable(acc) && $stable(zero_flag) && done)
        else $error("refused direction load changed state");

    a_dir_insn_wins: assert property (@(posedge clk) disable iff (srst)
        insn_valid && ((insn & LPD_MASK) == LPD_CODE) && insn[2:0] == 3'h6 && mem_we && mem_addr == DIR_ADDR_6
        |=> dir6 == $past(acc))
        else $error("direct write beat a direction load");

    // XOR instructions leave the direction registers alone.
    a_lit_keeps_dirs: assert property (@(posedge clk) disable iff (srst)
        s_lit_issue ##0 !mem_we |=> $stable(dir5) && $stable(dir6) && $stable(dir7) && !file_we)
        else $error("literal XOR touched direction or file");

    a_file_keeps_dirs: assert property (@(posedge clk) disable iff (srst)
        s_file_issue(1'b1) |=> $stable(dir5) && $stable(dir6) && $stable(dir7))
        else $error("file XOR touched a direction register");

    a_file_zero_acc: assert property (@(posedge clk) disable iff (srst)
        s_file_issue(1'b0) |=> zero_flag == (acc == 8'h00))
        else $error("file XOR to accumulator zero flag wrong");

    // Without an instruction nothing may execute.
    a_idle_quiet: assert property (@(posedge clk) disable iff (srst)
        !insn_valid |=> !done && !file_we && $stable(acc) && $stable(zero_flag))
        else $error("state changed with no instruction");

    a_done_has_cause: assert property (@(posedge clk) disable iff (srst)
        done |-> $past(insn_valid))
        else $error("done without an instruction");
endmodule

// >>> verif/xadl_fmem.sv
`timescale 1ns/1ps
module xadl_fmem (
    input wire logic clk,
    input wire logic [xadl_pkg::ADDR_W-1:0] rd_addr,
    output logic [xadl_pkg::DATA_W-1:0] rdata,
    input wire logic we,
    input wire logic [xadl_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [xadl_pkg::DATA_W-1:0] wdata
);
    import xadl_pkg::*;
    logic [DATA_W-1:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    assign rdata = mem[rd_addr];
    always @(posedge clk) if (we) mem[wr_addr] <= wdata;
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import xadl_pkg::*;
    logic clk = 1'b0, srst = 1'b1, insn_valid = 1'b0, mem_we = 1'b0;
    logic [INSN_W-1:0] insn = '0;
    logic [ADDR_W-1:0] mem_addr = '0, file_addr;
    logic [DATA_W-1:0] mem_wdata = '0, file_rdata, file_wdata, acc, dir5, dir6, dir7, dir_rdata;
    logic file_we, zero_flag, dir_rd_hit, done, ez = ZERO_RST;
    logic [DATA_W-1:0] ea = ACC_RST, e5 = DIR_RST, e6 = DIR_RST, e7 = DIR_RST;
    logic [31:0] lf = 32'h15BC;
    int n_mismatch = 0, n_checks = 0;
    always #25 clk = ~clk;
    xadl_core dut (.clk(clk), .srst(srst), .insn_valid(insn_valid), .insn(insn), .file_rdata(file_rdata),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag), .dir5(dir5), .dir6(dir6), .dir7(dir7),
        .dir_rd_hit(dir_rd_hit), .dir_rdata(dir_rdata), .done(done));
    xadl_fmem fm (.clk(clk), .rd_addr(insn[ADDR_W-1:0]), .rdata(file_rdata), .we(file_we),
        .wr_addr(file_addr), .wdata(file_wdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic op(input logic [INSN_W-1:0] w);
        logic [DATA_W-1:0] r;
        logic we, ed;
        @(posedge clk);
        insn <= w;
        insn_valid <= 1'b1;
        @(posedge clk);
        insn_valid <= 1'b0;
        r = ea ^ fm.mem[w[ADDR_W-1:0]];
        we = 1'b0;
        ed = 1'b1;
        if ((w & XLA_MASK) == XLA_CODE) begin
            ea = ea ^ w[7:0];
            ez = (ea == 8'h00);
        end else if ((w & XAF_MASK) == XAF_CODE) begin
            ez = (r == 8'h00);
            we = w[DEST_BIT];
            if (!we) ea = r;
        end else if ((w & LPD_MASK) == LPD_CODE) begin
            if (w[2:0] == 3'h5) e5 = ea;
            if (w[2:0] == 3'h6) e6 = ea;
            if (w[2:0] == 3'h7) e7 = ea;
        end else ed = 1'b0;
        #1;
        chk("acc", ea, acc);
        chk("zero", ez, zero_flag);
        chk("dirs", {e5, e6, e7}, {dir5, dir6, dir7});
        chk("done", ed, done);
        chk("file_we", we, file_we);
        if (we) chk("file_wr", {w[ADDR_W-1:0], r}, {file_addr, file_wdata});
    endtask
    task automatic dwr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic hit;
        @(posedge clk);
        mem_we <= 1'b1;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk);
        mem_we <= 1'b0;
        @(posedge clk);
        hit = (a >= DIR_ADDR_5 && a <= DIR_ADDR_7);
        if (a == DIR_ADDR_5) e5 = d;
        if (a == DIR_ADDR_6) e6 = d;
        if (a == DIR_ADDR_7) e7 = d;
        #1;
        chk("dirs", {e5, e6, e7}, {dir5, dir6, dir7});
        chk("dir_read", {hit, hit ? d : 8'h00}, {dir_rd_hit, dir_rdata});
    endtask
    task automatic both(input logic [2:0] f, input logic [DATA_W-1:0] d);
        @(posedge clk);
        insn <= {11'h00C, f};
        insn_valid <= 1'b1;
        mem_we <= 1'b1;
        mem_addr <= {4'h0, f};
        mem_wdata <= d;
        @(posedge clk);
        insn_valid <= 1'b0;
        mem_we <= 1'b0;
        if (f == 3'h5) e5 = ea;
        if (f == 3'h6) e6 = ea;
        if (f == 3'h7) e7 = ea;
        #1;
        chk("dirs", {e5, e6, e7}, {dir5, dir6, dir7});
        chk("done", 1'b1, done);
    endtask
    initial begin
        #5000000;
        n_mismatch++;
        close_out;
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        op(14'h3A00);
        op(14'h3AFF);
        for (int s = 0; s < 8; s++) op(14'h0060 | 14'(s));
        op(14'h06FF);
        op(14'h067F);
        $display("test corners done");
        for (int a = 4; a < 9; a++) begin
            lf = lfsr(lf);
            dwr(7'(a), lf[7:0]);
        end
        $display("test direct access done");
        for (int f = 5; f < 8; f++) begin
            lf = lfsr(lf);
            both(3'(f), lf[7:0]);
        end
        $display("test priority done");
        for (int i = 0; i < 300; i++) begin
            lf = lfsr(lf);
            case (lf[1:0])
                2'h0: op({6'h3A, lf[15:8]});
                2'h1: op({6'h06, lf[15], 1'b1, lf[13:8]});
                2'h2: op({11'h00C, lf[10:8]});
                default: op(lf[29:16] | 14'h0040);
            endcase
        end
        $display("test random done");
        close_out;
    end
endmodule
